// ### design/flash_host_defines.svh
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

`define CMD_READ_ARRAY    8'hff
`define CMD_READ_ID       8'h90
`define CMD_QUERY         8'h98
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_PROGRAM       8'h40
`define CMD_SUSPEND       8'hb0
`define CMD_RESUME        8'hd0

`define ID_OFS_MAKER      8'h00
`define ID_OFS_PART       8'h01
`define ID_OFS_LOCK       8'h02
`define ID_OFS_PROT_LOCK  8'h80
`define ID_OFS_PROT_DATA  8'h81

`define SR_READY_BIT      7
`define SR_SUSPEND_BIT    2
`define SR_ERR_MASK       8'h3a

// Bus timing in ns, turned into ref_clk cycles
`define SETUP_NS          20
`define STROBE_NS         70
`define RESET_LOW_NS      100
`define WAKE_NS           150
`define CLK_PERIOD_NS     4
`define NS_TO_CYC(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W             8
`define ADDR_W            22
`define DATA_W            16

`endif

// ### design/flash_host_pkg.sv
package flash_host_pkg;
  typedef enum logic [2:0] {
    OP_READ      = 3'b000,
    OP_WRITE     = 3'b001,
    OP_RESET     = 3'b010,
    OP_POLL      = 3'b011,
    OP_PROGRAM   = 3'b100
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_RST_LOW   = 4'b0001,
    ST_RST_WAKE  = 4'b0010,
    ST_WR_SETUP  = 4'b0011,
    ST_WR_STROBE = 4'b0100,
    ST_WR_HOLD   = 4'b0101,
    ST_RD_SETUP  = 4'b0110,
    ST_RD_STROBE = 4'b0111,
    ST_RD_DONE   = 4'b1000,
    ST_PG_DATA   = 4'b1001,
    ST_POLL_GAP  = 4'b1010
  } state_t;
endpackage : flash_host_pkg

// ### design/pin_sync.sv
`timescale 1ns/1ps
`include "flash_host_defines.svh"

// Three-stage capture of data pins; a bit changes once stages two and three agree
module pin_sync (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [`DATA_W-1:0]   pin_in,
  output logic      [`DATA_W-1:0]   pin_out
);
  logic [`DATA_W-1:0] s1_r;
  logic [`DATA_W-1:0] s2_r;
  logic [`DATA_W-1:0] s3_r;
  logic [`DATA_W-1:0] out_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `DATA_W; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          out_r[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          out_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate

  assign pin_out = out_r;
endmodule : pin_sync

// ### design/flash_host_ctrl.sv
`timescale 1ns/1ps
`include "flash_host_defines.svh"

module flash_host_ctrl (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // User side
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire flash_host_pkg::op_t  req_op,
  input  wire logic [`ADDR_W-1:0]   req_addr,
  input  wire logic [`DATA_W-1:0]   req_data,
  output logic                      rsp_valid,
  output logic [`DATA_W-1:0]        rsp_data,
  output logic                      suspended,
  // Flash pins
  output logic [`ADDR_W-1:0]        addr_pin,
  input  wire logic [`DATA_W-1:0]   dq_in,
  output logic [`DATA_W-1:0]        dq_out,
  output logic                      dq_oe,
  output logic                      chip_sel_n,
  output logic                      out_en_n,
  output logic                      wr_strobe_n,
  output logic                      reset_pin_n
);
  localparam logic [`CNT_W-1:0] SETUP_CYC  = `CNT_W'(`NS_TO_CYC(`SETUP_NS));
  localparam logic [`CNT_W-1:0] STROBE_CYC = `CNT_W'(`NS_TO_CYC(`STROBE_NS));
  localparam logic [`CNT_W-1:0] RSTLO_CYC  = `CNT_W'(`NS_TO_CYC(`RESET_LOW_NS));
  localparam logic [`CNT_W-1:0] WAKE_CYC   = `CNT_W'(`NS_TO_CYC(`WAKE_NS));

  flash_host_pkg::state_t state_r;
  flash_host_pkg::op_t    op_r;
  logic [`CNT_W-1:0]      cnt_r;
  logic [`ADDR_W-1:0]     addr_r;
  logic [`DATA_W-1:0]     wdata_r;
  logic [`DATA_W-1:0]     rdata_r;
  logic                   rsp_r;
  logic                   susp_r;
  logic [`DATA_W-1:0]     dq_sync;
  logic                   cnt_done;

  function automatic logic is_cmd(input logic [`DATA_W-1:0] d, input logic [7:0] c);
    is_cmd = (d[7:0] == c);
  endfunction : is_cmd

  pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (dq_in),
    .pin_out (dq_sync)
  );

  assign cnt_done  = (cnt_r == '0);
  assign req_ready = (state_r == flash_host_pkg::ST_IDLE);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= flash_host_pkg::ST_RST_LOW;
      cnt_r   <= RSTLO_CYC;
    end else begin
      case (state_r)
        flash_host_pkg::ST_IDLE: begin
          if (req_valid) begin
            cnt_r <= SETUP_CYC;
            case (req_op)
              flash_host_pkg::OP_RESET:   begin
                state_r <= flash_host_pkg::ST_RST_LOW;
                cnt_r   <= RSTLO_CYC;
              end
              flash_host_pkg::OP_WRITE:   state_r <= flash_host_pkg::ST_WR_SETUP;
              flash_host_pkg::OP_PROGRAM: state_r <= flash_host_pkg::ST_WR_SETUP;
              default:                    state_r <= flash_host_pkg::ST_RD_SETUP;
            endcase
          end
        end
        flash_host_pkg::ST_RST_LOW: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            state_r <= flash_host_pkg::ST_RST_WAKE;
            cnt_r   <= WAKE_CYC;
          end
        end
        flash_host_pkg::ST_WR_SETUP, flash_host_pkg::ST_RD_SETUP, flash_host_pkg::ST_POLL_GAP: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            cnt_r   <= STROBE_CYC;
            state_r <= (state_r == flash_host_pkg::ST_WR_SETUP) ? flash_host_pkg::ST_WR_STROBE
                                                                : flash_host_pkg::ST_RD_STROBE;
          end
        end
        flash_host_pkg::ST_WR_STROBE, flash_host_pkg::ST_RD_STROBE: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            cnt_r   <= SETUP_CYC;
            state_r <= (state_r == flash_host_pkg::ST_WR_STROBE) ? flash_host_pkg::ST_WR_HOLD
                                                                 : flash_host_pkg::ST_RD_DONE;
          end
        end
        flash_host_pkg::ST_WR_HOLD: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            // Program set-up then second write with address and data
            state_r <= (op_r == flash_host_pkg::OP_PROGRAM) ? flash_host_pkg::ST_PG_DATA
                                                            : flash_host_pkg::ST_IDLE;
            cnt_r   <= SETUP_CYC;
          end
        end
        flash_host_pkg::ST_PG_DATA: begin
          state_r <= flash_host_pkg::ST_WR_SETUP;
        end
        flash_host_pkg::ST_RD_DONE: begin
          // Poll repeats with a fresh strobe per read until ready bit
          if (op_r == flash_host_pkg::OP_POLL && !dq_sync[`SR_READY_BIT]) begin
            state_r <= flash_host_pkg::ST_POLL_GAP;
            cnt_r   <= SETUP_CYC;
          end else begin
            state_r <= flash_host_pkg::ST_IDLE;
          end
        end
        default: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_done) begin
            state_r <= flash_host_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Request capture
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_r    <= flash_host_pkg::OP_READ;
      addr_r  <= '0;
      wdata_r <= '0;
    end else if (state_r == flash_host_pkg::ST_IDLE && req_valid) begin
      op_r    <= req_op;
      addr_r  <= req_addr;
      wdata_r <= (req_op == flash_host_pkg::OP_PROGRAM) ? `DATA_W'(`CMD_PROGRAM) : req_data;
    end else if (state_r == flash_host_pkg::ST_PG_DATA) begin
      op_r    <= flash_host_pkg::OP_WRITE;
      wdata_r <= req_data;
    end
  end

  // Answer, taken while strobe still low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= '0;
      rsp_r   <= 1'b0;
    end else begin
      rsp_r <= 1'b0;
      if (state_r == flash_host_pkg::ST_RD_STROBE && cnt_done) begin
        rdata_r <= dq_sync;
      end
      if (state_r == flash_host_pkg::ST_RD_DONE &&
          !(op_r == flash_host_pkg::OP_POLL && !dq_sync[`SR_READY_BIT])) begin
        rsp_r <= 1'b1;
      end
    end
  end

  // Suspend tracking from issued commands
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      susp_r <= 1'b0;
    end else if (state_r == flash_host_pkg::ST_RST_LOW) begin
      susp_r <= 1'b0;
    end else if (state_r == flash_host_pkg::ST_WR_HOLD && cnt_done && op_r == flash_host_pkg::OP_WRITE) begin
      if (is_cmd(wdata_r, `CMD_SUSPEND)) begin
        susp_r <= 1'b1;
      end else if (is_cmd(wdata_r, `CMD_RESUME)) begin
        susp_r <= 1'b0;
      end
    end
  end

  // Pins: strobe rises while address and data still held
  always_comb begin
    reset_pin_n = (state_r != flash_host_pkg::ST_RST_LOW);
    chip_sel_n  = !(state_r == flash_host_pkg::ST_WR_STROBE || state_r == flash_host_pkg::ST_RD_STROBE ||
                    state_r == flash_host_pkg::ST_WR_HOLD);
    wr_strobe_n = (state_r != flash_host_pkg::ST_WR_STROBE);
    out_en_n    = (state_r != flash_host_pkg::ST_RD_STROBE);
    dq_oe       = (state_r == flash_host_pkg::ST_WR_SETUP || state_r == flash_host_pkg::ST_WR_STROBE ||
                   state_r == flash_host_pkg::ST_WR_HOLD);
  end

  assign addr_pin  = addr_r;
  assign dq_out    = wdata_r;
  assign rsp_valid = rsp_r;
  assign rsp_data  = rdata_r;
  assign suspended = susp_r;

  // Reset pin never pulses low while a program is suspended unless asked
  property p_reset_hold;
    @(posedge ref_clk) disable iff (rst)
      (susp_r && state_r == flash_host_pkg::ST_IDLE && !(req_valid && req_op == flash_host_pkg::OP_RESET))
      |=> reset_pin_n;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset pin dropped while suspended");

  property p_read_pins;
    @(posedge ref_clk) disable iff (rst)
      !out_en_n |-> (!chip_sel_n && wr_strobe_n && reset_pin_n && !dq_oe);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("bad pin levels in read");

  sequence s_wr_strobe;
    !wr_strobe_n [*2];
  endsequence
  property p_write_latch;
    @(posedge ref_clk) disable iff (rst)
      s_wr_strobe ##1 wr_strobe_n |-> (!chip_sel_n && dq_oe && $stable(addr_pin) && $stable(dq_out));
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("data not held at strobe rise");

  property p_program_second;
    @(posedge ref_clk) disable iff (rst)
      (state_r == flash_host_pkg::ST_PG_DATA) |=> (dq_oe && wr_strobe_n) ##[1:40] !wr_strobe_n;
  endproperty
  a_program_second: assert property (p_program_second) else $error("program data write missing");

  // Poll ends with a ready answer, or releases both strobes before the next read
  property p_poll_toggle;
    @(posedge ref_clk) disable iff (rst)
      ($rose(out_en_n) && op_r == flash_host_pkg::OP_POLL) |=>
        ((rsp_valid && rsp_data[`SR_READY_BIT]) || (!rsp_valid && chip_sel_n && out_en_n));
  endproperty
  a_poll_toggle: assert property (p_poll_toggle) else $error("poll without toggle");

  property p_idle_pins;
    @(posedge ref_clk) disable iff (rst)
      req_ready |-> (chip_sel_n && out_en_n && wr_strobe_n && reset_pin_n && !dq_oe);
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("bus not released in idle");
endmodule : flash_host_ctrl

// ### verification/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5,
  parameter logic [15:0] PART_CODE  = 16'h5a3c,
  parameter int          PROG_NS    = 2000
) (
  input  wire logic [21:0] addr_pin,
  input  wire logic [15:0] dq_out,
  input  wire logic        dq_oe,
  input  wire logic        chip_sel_n,
  input  wire logic        out_en_n,
  input  wire logic        wr_strobe_n,
  input  wire logic        reset_pin_n,
  output logic      [15:0] dev_dq
);
  typedef enum logic [1:0] {M_ARRAY, M_ID, M_QUERY, M_STATUS} mode_t;
  mode_t        mode    = M_ARRAY;
  logic [15:0]  mem     [256];
  logic [127:0] lock_r  = {128{1'b1}};
  logic [7:0]   sr      = 8'h80;
  logic [7:0]   sr_lat  = 8'h80;
  logic [15:0]  last    = 16'h0000;
  logic [21:0]  pa      = 22'h000000;
  logic [15:0]  pd      = 16'h0000;
  logic         busy    = 1'b0;
  logic         halt    = 1'b0;
  logic         sus_req = 1'b0;
  logic         wr_act  = 1'b0;
  logic [1:0]   pend    = 2'h0;
  int           left    = 0;
  wire          rd_on   = !chip_sel_n && !out_en_n && wr_strobe_n && reset_pin_n;
  // Released bus shows the inverse of the last value
  wire  [15:0]  bus     = dq_oe ? dq_out : ~last;

  initial for (int i = 0; i < 256; i++) mem[i] = {~i[7:0], i[7:0]};

  function automatic logic [15:0] rd_word(input logic [21:0] a);
    case (mode)
      M_ARRAY:  rd_word = mem[a[7:0]];
      M_QUERY:  rd_word = {8'h00, a[7:0] ^ 8'h3c};
      M_STATUS: rd_word = {8'h00, sr_lat};
      default:  rd_word = (a[7:0] == 8'h00) ? MAKER_CODE : (a[7:0] == 8'h01) ? PART_CODE :
                          (a[7:0] == 8'h02) ? {15'h0000, lock_r[a[21:15]]} :
                          (a[7:0] == 8'h80) ? 16'h0002 : 16'h1100 + {8'h00, a[7:0]} - 16'h0081;
    endcase
  endfunction : rd_word

  always @(rd_on or addr_pin or mode or sr_lat or lock_r) begin
    if (rd_on) begin
      dev_dq = rd_word(addr_pin);
      last = dev_dq;
    end else dev_dq = ~last;
  end

  always @(negedge chip_sel_n or negedge out_en_n) if (!chip_sel_n && !out_en_n) sr_lat = sr;

  task automatic cmd(input logic [21:0] a, input logic [7:0] c, input logic [15:0] d);
    if (pend == 2'h1) begin
      pend = 2'h0;
      if (lock_r[a[21:15]]) sr[1] = 1'b1;
      else begin
        pa = a;
        pd = d;
        busy = 1'b1;
        sr[7] = 1'b0;
        left = PROG_NS / 10;
      end
    end else if (pend == 2'h2) begin
      pend = 2'h0;
      if (c == 8'hd0) lock_r[a[21:15]] = 1'b0;
    end else if (busy && !halt) begin
      if (c == 8'hb0) sus_req = 1'b1;
      if (c == 8'h70 || c == 8'hb0) mode = M_STATUS;
    end else if (halt) begin
      case (c)
        8'hff: mode = M_ARRAY;
        8'h70: mode = M_STATUS;
        8'h90: mode = M_ID;
        8'h98: mode = M_QUERY;
        8'hd0: begin
          halt = 1'b0;
          sr = sr & 8'h7b;
          mode = M_STATUS;
        end
        default: ;
      endcase
    end else begin
      case (c)
        8'hff: mode = M_ARRAY;
        8'h90: mode = M_ID;
        8'h98: mode = M_QUERY;
        8'h70: mode = M_STATUS;
        8'h50: sr = sr & 8'hc5;
        8'h40: begin
          pend = 2'h1;
          mode = M_STATUS;
        end
        8'h60: pend = 2'h2;
        default: ;
      endcase
    end
  endtask : cmd

  always @(negedge chip_sel_n or negedge wr_strobe_n) if (!chip_sel_n && !wr_strobe_n && reset_pin_n) wr_act = 1'b1;
  always @(posedge chip_sel_n or posedge wr_strobe_n) begin
    if (wr_act) begin
      wr_act = 1'b0;
      cmd(addr_pin, bus[7:0], bus);
    end
  end

  always #10 begin
    if (busy && sus_req) begin
      halt = 1'b1;
      sus_req = 1'b0;
      sr = sr | 8'h84;
    end else if (busy && !halt) begin
      if (left == 0) begin
        mem[pa[7:0]] = mem[pa[7:0]] & pd;
        busy = 1'b0;
        sr[7] = 1'b1;
      end else left--;
    end
  end

  always @(negedge reset_pin_n) begin
    mode = M_ARRAY;
    sr = 8'h80;
    lock_r = {128{1'b1}};
    busy = 1'b0;
    halt = 1'b0;
    sus_req = 1'b0;
    pend = 2'h0;
  end
endmodule : flash_model

// ### verification/flash_host_ctrl_bench.sv
`timescale 1ns/1ps
`include "flash_host_defines.svh"
module flash_host_ctrl_bench;
  localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
  localparam logic [15:0] PART  = 16'h5a3c; // Arbitrary value
  logic                ref_clk   = 1'b0;
  logic                rst       = 1'b1;
  logic                req_valid = 1'b0;
  flash_host_pkg::op_t req_op    = flash_host_pkg::OP_READ;
  logic [`ADDR_W-1:0]  req_addr  = 22'h000000;
  logic [`DATA_W-1:0]  req_data  = 16'h0000;
  logic                req_ready, rsp_valid, suspended, dq_oe, chip_sel_n, out_en_n, wr_strobe_n, reset_pin_n;
  logic [`DATA_W-1:0]  rsp_data, dq_out, dev_dq, got;
  logic [`ADDR_W-1:0]  addr_pin;
  wire  [`DATA_W-1:0]  dq_in     = dq_oe ? dq_out : dev_dq;
  int                  failures  = 0;
  int                  checks    = 0;

  always #2 ref_clk = ~ref_clk;

  flash_host_ctrl i_flash_host_ctrl (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .suspended(suspended), .addr_pin(addr_pin), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .reset_pin_n(reset_pin_n));
  flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .PROG_NS(2000)) i_flash_model (.addr_pin(addr_pin),
    .dq_out(dq_out), .dq_oe(dq_oe), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
    .reset_pin_n(reset_pin_n), .dev_dq(dev_dq));

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic access(input flash_host_pkg::op_t op, input logic [21:0] a, input logic [15:0] d);
    int   n;
    logic rd_op;
    n = 0;
    rd_op = (op == flash_host_pkg::OP_READ || op == flash_host_pkg::OP_POLL);
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    // Ready looked at once settled; the next edge takes the request
    while (req_ready !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    // Reads wait for the answer, other requests until the block is idle again
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while ((rd_op ? rsp_valid : req_ready) !== 1'b1 && n < 6000);
    if (rd_op) got = rsp_data;
    if (n >= 3000) begin
      failures++;
      results();
    end
  endtask : access

  task automatic wr(input logic [7:0] c);
    access(flash_host_pkg::OP_WRITE, 22'h000000, {8'h00, c});
  endtask : wr

  task automatic rd(input logic [21:0] a, input logic [15:0] exp);
    access(flash_host_pkg::OP_READ, a, 16'h0000);
    check(got, exp);
  endtask : rd

  task automatic poll(input logic [15:0] exp);
    access(flash_host_pkg::OP_POLL, 22'h000000, 16'h0000);
    check(got, exp);
  endtask : poll

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    rd(22'h000005, 16'hfa05);
    wr(`CMD_READ_ID);
    rd(22'h008000, MAKER);
    rd(22'h008001, PART);
    rd(22'h008002, 16'h0001);
    rd(22'h008080, 16'h0002);
    for (int i = 0; i < 8; i++) rd(22'h008081 + 22'(i), 16'h1100 + 16'(i));
    wr(`CMD_QUERY);
    rd(22'h000010, 16'h002c);
    wr(`CMD_READ_ARRAY);
    rd(22'h000010, 16'hef10);
    access(flash_host_pkg::OP_PROGRAM, 22'h000003, 16'h0f0f);
    poll(16'h0082);
    wr(`CMD_READ_STATUS);
    rd(22'h000003, 16'h0082);
    wr(`CMD_CLEAR_STATUS);
    rd(22'h000003, 16'h0080);
    wr(8'h60);
    wr(8'hd0);
    access(flash_host_pkg::OP_PROGRAM, 22'h000003, 16'h0f0f);
    poll(16'h0080);
    wr(`CMD_READ_ARRAY);
    rd(22'h000003, 16'h0c03);
    access(flash_host_pkg::OP_PROGRAM, 22'h000004, 16'h0000);
    wr(`CMD_READ_ID);
    rd(22'h000004, 16'h0000);
    wr(`CMD_SUSPEND);
    check({15'h0000, suspended}, 16'h0001);
    poll(16'h0084);
    wr(`CMD_READ_ARRAY);
    rd(22'h000009, 16'hf609);
    wr(`CMD_RESUME);
    check({15'h0000, suspended}, 16'h0000);
    poll(16'h0080);
    wr(`CMD_READ_ARRAY);
    rd(22'h000004, 16'h0000);
    access(flash_host_pkg::OP_RESET, 22'h000000, 16'h0000);
    rd(22'h000003, 16'h0c03);
    access(flash_host_pkg::OP_PROGRAM, 22'h000003, 16'h0000);
    poll(16'h0082);
    access(flash_host_pkg::OP_RESET, 22'h000000, 16'h0000);
    wr(`CMD_READ_STATUS);
    rd(22'h000000, 16'h0080);
    results();
  end
endmodule : flash_host_ctrl_bench
